// ### dv/tb_top.sv
`timescale 1ns/1ps
// Bench with an integer model of both flag registers checked at every read.
module tb_top;
   import tifu_pkg::*;
   logic core_clk = 1'b0, nrst = 1'b0, en = 1'b0, wl = 1'b0, nvd = 1'b0, nve = 1'b0;
   logic [6:0] mev = '0;
   logic [7:0] aev = '0, rdata;
   logic irq, rd_d = 1'b0;
   logic [31:0] r;
   tifu_req_s tb_req = '0, mcu_req, req;
   int errors = 0, n_checks = 0, seed = 69303, mm = 0, am = 0, exp_d = 0;
   int msk[16] = '{2: 255, 3: 255, 5: 3, default: 0};
   assign req = tifu_req_s'(tb_req | mcu_req);
   always #5 core_clk = ~core_clk;
   tifu_flags tifu_flags_inst (.core_clk(core_clk), .nrst(nrst), .main_evt(mev),
      .water_level_evt(wl), .aux_evt(aev), .nv_write_done_evt(nvd),
      .nv_write_error_flag(nve), .req(req), .rdata(rdata), .irq(irq));
   tifu_mcu tifu_mcu_inst (.core_clk(core_clk), .nrst(nrst), .en(en), .irq(irq),
      .rdata(rdata), .req(mcu_req));
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Model: an event in the cycle of a clearing read survives it.
   always @(posedge core_clk)
   begin
      if (rd_d)
         chk(rdata, exp_d[7:0]);
      rd_d <= req.rd;
      exp_d <= req.addr == OFS_MAIN ? {am != 0, mm[6:0]}
         : req.addr == OFS_AUX ? am : msk[req.addr];
      if (req.wr && req.addr inside {OFS_MAIN_MASK, OFS_AUX_MASK, OFS_STAT_MASK})
         msk[req.addr] <= req.wdata;
      mm <= (req.rd && req.addr == OFS_MAIN ? 0 : mm) | mev | wl;
      am <= (req.rd && req.addr == OFS_AUX ? 0 : am) | aev | nvd | nve << 1;
   end
   task op(input logic w, input logic [3:0] a, input logic [7:0] d);
      tb_req <= '{a, d, w, !w};
      @(posedge core_clk);
   endtask
   task ev(input logic [6:0] m, input logic [7:0] x);
      tb_req <= '0;
      mev <= m;
      aev <= x;
      @(posedge core_clk);
   endtask
   task test_done;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Watchdog, well beyond the expected run.
   initial
   begin
      #100us;
      errors++;
      test_done;
   end
   initial
   begin
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      for (int a = 0; a < 16; a++)
         if (a != 4)
            op(1'b0, 4'(a), 8'h00);
      op(1'b1, OFS_MAIN, 8'hff);
      op(1'b1, OFS_AUX, 8'hff);
      ev(7'h08, 8'h00);
      ev(7'h40, 8'h00);
      ev(7'h00, 8'h00);
      repeat (3) @(posedge core_clk);
      chk(irq, 1'b1);
      mev <= 7'h20;
      op(1'b0, OFS_MAIN, 8'h00);
      mev <= 7'h00;
      op(1'b0, OFS_MAIN, 8'h00);
      op(1'b1, OFS_STAT, 8'h03);
      chk(irq, 1'b0);
      ev(7'h00, 8'h00);
      repeat (3) @(posedge core_clk);
      chk(irq, 1'b0);
      ev(7'h00, 8'h04);
      ev(7'h00, 8'h00);
      op(1'b0, OFS_MAIN, 8'h00);
      op(1'b0, OFS_MAIN, 8'h00);
      op(1'b0, OFS_AUX, 8'h00);
      op(1'b0, OFS_MAIN, 8'h00);
      chk(irq, 1'b0);
      op(1'b1, OFS_STAT_MASK, 8'h00);
      op(1'b0, OFS_STAT_MASK, 8'h00);
      ev(7'h01, 8'h00);
      ev(7'h00, 8'h00);
      repeat (4) @(posedge core_clk);
      chk(irq, 1'b0);
      op(1'b0, OFS_MAIN, 8'h00);
      op(1'b1, OFS_STAT, 8'h03);
      op(1'b1, OFS_STAT_MASK, 8'h03);
      ev(7'h00, 8'h00);
      en <= 1'b1;
      // Sparse random events while the controller model services them.
      repeat (3000)
      begin
         @(posedge core_clk);
         r = $random(seed);
         mev <= r[3:0] == 0 ? r[10:4] : 7'h00;
         aev <= r[15:11] == 0 ? r[23:16] : 8'h00;
         wl <= r[28:24] == 0;
         nvd <= r[31:27] == 1;
         nve <= r[31:27] == 2;
      end
      @(posedge core_clk);
      {mev, aev, wl, nvd, nve} <= '0;
      repeat (41) @(posedge core_clk);
      chk(irq, 1'b0);
      test_done;
   end
endmodule

// ### dv/tifu_mcu.sv
`timescale 1ns/1ps
// Controller model: reads main, then aux if flagged, then clears status.
module tifu_mcu
   import tifu_pkg::*;
(
   // Clock, reset and enable.
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic en,
   // From the flag unit.
   input wire logic irq,
   input wire logic [7:0] rdata,
   // Requests.
   output tifu_req_s req
);
   int st;
   // One strobe per step; read data is looked at in the cycle after it.
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st <= 0;
         req <= '0;
      end
      else
      begin
         req <= '0;
         st <= (st == 0 || st == 7) ? 0 : st + 1;
         if (st == 0 && irq && en)
         begin
            req <= '{OFS_MAIN, 8'h00, 1'b0, 1'b1};
            st <= 1;
         end
         if (st == 2 && rdata[MAIN_AUX_BIT])
            req <= '{OFS_AUX, 8'h00, 1'b0, 1'b1};
         if (st == 4)
            req <= '{OFS_STAT, 8'h03, 1'b1, 1'b0};
      end
   end
endmodule

// ### hdl/tifu_flags.sv
`timescale 1ns/1ps
// Behaviour
// - Main register: seven sources plus aux summary.
// - Event sets flag and raises interrupt if unmasked.
// - Reading a flag register clears its flags.
// - Summary clears only on auxiliary read.
// - Interrupt drops once causing flags read.
// - Flags accumulate; no event is lost.
// - Nonvolatile write done or error sets aux.
// - Water level event sets main flag.
module tifu_flags
   import tifu_pkg::*;
#(
   parameter int SRC_W = MAIN_SRC_W
)
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic nrst,
   // Event pulses from the neighbouring blocks, same clock.
   input wire logic [SRC_W-1:0] main_evt,
   input wire logic water_level_evt,
   input wire logic [AUX_W-1:0] aux_evt,
   input wire logic nv_write_done_evt,
   input wire logic nv_write_error_flag,
   // Software port.
   input wire tifu_req_s req,
   output logic [REG_W-1:0] rdata,
   // Interrupt request toward the controller.
   output logic irq
);

   // Elaboration check: the fixed register layout has room for exactly seven sources.
   if (SRC_W != MAIN_SRC_W)
   begin : g_bad_src_w
      $error("tifu_flags supports exactly seven main sources");
   end

   logic [REG_W-1:0] main_q, main_d, aux_q, aux_d;
   logic [REG_W-1:0] main_mask_q, aux_mask_q;
   logic [ST_W-1:0] st_q, st_d, st_mask_q;
   logic [REG_W-1:0] rdata_q, rdata_d;
   logic irq_q, irq_d;

   // Address decode as named wires.
   wire rd_main = req.rd && (req.addr == OFS_MAIN);
   wire rd_aux = req.rd && (req.addr == OFS_AUX);
   wire wr_mmask = req.wr && (req.addr == OFS_MAIN_MASK);
   wire wr_amask = req.wr && (req.addr == OFS_AUX_MASK);
   wire wr_st = req.wr && (req.addr == OFS_STAT);
   wire wr_stmask = req.wr && (req.addr == OFS_STAT_MASK);

   // Collected sources; water level is ORed onto bit 0, shared with main source 0.
   wire [SRC_W-1:0] src_main = main_evt | ({{(SRC_W-1){1'b0}}, water_level_evt}
                                           << MAIN_WL_BIT);
   wire [AUX_W-1:0] src_aux = aux_evt
      | (AUX_W'(nv_write_done_evt) << AUX_NVDONE_BIT)
      | (AUX_W'(nv_write_error_flag) << AUX_NVERR_BIT);

   // Next flags: a read clears, but new events are ORed after the clear so none is lost.
   wire [AUX_W-1:0] aux_keep = rd_aux ? '0 : aux_q;
   assign aux_d = aux_keep | src_aux;
   wire [SRC_W-1:0] main_keep = rd_main ? '0 : main_q[SRC_W-1:0];
   // Summary ignores main reads and follows aux contents after an aux read.
   wire sum_d = rd_aux ? (|src_aux) : (main_q[MAIN_AUX_BIT] | (|src_aux));
   assign main_d = {sum_d, main_keep | src_main};

   // Status of unmasked pending flags, sticky, write one to clear; set wins.
   wire main_pend = |(main_d & main_mask_q);
   wire aux_pend = |(aux_d & aux_mask_q);
   wire [ST_W-1:0] st_set = {aux_pend, main_pend};
   assign st_d = (st_q & ~(wr_st ? req.wdata[ST_W-1:0] : '0)) | st_set;

   // Interrupt follows the unmasked pending flags, so reading them is enough to drop it.
   // The sticky status only records for software which group was pending.
   assign irq_d = |(st_set & st_mask_q);

   // Read mux, registered for one-cycle-later data.
   always_comb
   begin
      case (req.addr)
         OFS_MAIN: rdata_d = main_q;
         OFS_AUX: rdata_d = aux_q;
         OFS_MAIN_MASK: rdata_d = main_mask_q;
         OFS_AUX_MASK: rdata_d = aux_mask_q;
         OFS_STAT: rdata_d = {{(REG_W-ST_W){1'b0}}, st_q};
         OFS_STAT_MASK: rdata_d = {{(REG_W-ST_W){1'b0}}, st_mask_q};
         default: rdata_d = '0;
      endcase
      if (!req.rd)
         rdata_d = '0;
   end

   // Flag state.
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         main_q <= MAIN_RST;
         aux_q <= AUX_RST;
         st_q <= ST_RST;
      end
      else
      begin
         main_q <= main_d;
         aux_q <= aux_d;
         st_q <= st_d;
      end
   end

   // Masks and outputs.
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         main_mask_q <= MASK_RST;
         aux_mask_q <= MASK_RST;
         st_mask_q <= ST_MASK_RST;
         rdata_q <= '0;
         irq_q <= 1'b0;
      end
      else
      begin
         if (wr_mmask)
            main_mask_q <= req.wdata;
         if (wr_amask)
            aux_mask_q <= req.wdata;
         if (wr_stmask)
            st_mask_q <= req.wdata[ST_W-1:0];
         rdata_q <= rdata_d;
         irq_q <= irq_d;
      end
   end

   assign rdata = rdata_q;
   assign irq = irq_q;

   // Checks.
   AST_SET: assert property (@(posedge core_clk) disable iff (!nrst)
      water_level_evt |=> main_q[MAIN_WL_BIT])
      else $error("water level event not flagged");
   AST_NVERR: assert property (@(posedge core_clk) disable iff (!nrst)
      nv_write_error_flag |=> aux_q[AUX_NVERR_BIT])
      else $error("write error not flagged");
   AST_CLR: assert property (@(posedge core_clk) disable iff (!nrst)
      (rd_main && main_evt == '0 && !water_level_evt) |=> main_q[SRC_W-1:0] == '0)
      else $error("main read did not clear");
   AST_SUM_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
      (rd_main && !rd_aux && main_q[MAIN_AUX_BIT]) |=> main_q[MAIN_AUX_BIT])
      else $error("summary cleared by main read");
   AST_SUM_AUX: assert property (@(posedge core_clk) disable iff (!nrst)
      (|aux_q) |-> main_q[MAIN_AUX_BIT])
      else $error("summary missing while aux pending");
   AST_KEEP: assert property (@(posedge core_clk) disable iff (!nrst)
      (rd_main && main_evt[1]) |=> main_q[1])
      else $error("event lost during clearing read");
   AST_ACC: assert property (@(posedge core_clk) disable iff (!nrst)
      (main_q[2] && !rd_main) |=> main_q[2])
      else $error("flag lost without read");
   AST_IRQ: assert property (@(posedge core_clk) disable iff (!nrst)
      (main_evt[3] && main_mask_q[3] && st_mask_q[ST_MAIN_BIT]) |=> irq)
      else $error("interrupt not raised");
   AST_RDLAT: assert property (@(posedge core_clk) disable iff (!nrst)
      rd_main |=> rdata == $past(main_q))
      else $error("read data wrong");
   AST_IRQ_DROP: assert property (@(posedge core_clk) disable iff (!nrst)
      (!main_pend && !aux_pend) |=> !irq)
      else $error("interrupt held with no pending flag");
   AST_SUM_CLR: assert property (@(posedge core_clk) disable iff (!nrst)
      (rd_aux && src_aux == '0) |=> !main_q[MAIN_AUX_BIT])
      else $error("summary not cleared by aux read");

   COV_IRQ: cover property (@(posedge core_clk) disable iff (!nrst) $rose(irq));
   COV_AUXRD: cover property (@(posedge core_clk) disable iff (!nrst)
      main_q[MAIN_AUX_BIT] ##1 rd_aux);
   COV_RACE: cover property (@(posedge core_clk) disable iff (!nrst) rd_main && |main_evt);
   COV_IRQ_DROP: cover property (@(posedge core_clk) disable iff (!nrst) $fell(irq));

endmodule

// ### pkg/tifu_pkg.sv
package tifu_pkg;

   // Flag register widths.
   localparam int MAIN_SRC_W = 7;
   localparam int AUX_W = 8;
   localparam int REG_W = 8;
   localparam int ADDR_W = 4;

   // Register offsets on the plain software port.
   localparam logic [3:0] OFS_MAIN = 4'h0;
   localparam logic [3:0] OFS_AUX = 4'h1;
   localparam logic [3:0] OFS_MAIN_MASK = 4'h2;
   localparam logic [3:0] OFS_AUX_MASK = 4'h3;
   localparam logic [3:0] OFS_STAT = 4'h4;
   localparam logic [3:0] OFS_STAT_MASK = 4'h5;

   // Field positions.
   localparam int MAIN_WL_BIT = 0;
   localparam int MAIN_AUX_BIT = 7;
   localparam int AUX_NVDONE_BIT = 0;
   localparam int AUX_NVERR_BIT = 1;

   // Bookkeeping status bits for the interrupt output.
   localparam int ST_MAIN_BIT = 0;
   localparam int ST_AUX_BIT = 1;
   localparam int ST_W = 2;

   // Reset values.
   localparam logic [7:0] MAIN_RST = 8'h00;
   localparam logic [7:0] AUX_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'hff;
   localparam logic [1:0] ST_RST = 2'h0;
   localparam logic [1:0] ST_MASK_RST = 2'h3;

   // Software port request bundle.
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tifu_req_s;

endpackage
